// >>> pfcb_top.sv
// forms control buffer carriage logic with apb register access
// assumes a single mclk domain; the printer parity pin is taken through a two-flop synchronizer
`timescale 1ns/10ps
`default_nettype none
module pfcb_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic plb_parity_err,
  output logic carriage_step,
  output logic lpi8,
  output logic irq
);
  import pfcb_pkg::*;

  logic [PFCB_EW-1:0] forms_control_buffer [PFCB_LINES];
  pfcb_state_t state_q;
  logic [PFCB_AW-1:0] line_q;
  logic [PFCB_AW-1:0] load_ptr_q;
  logic [3:0] want_q;
  logic [3:0] count_q;
  logic [1:0] top_seen_q;
  logic seen_last_q;
  logic bad_code_q;
  logic [7:0] sense_q [PFCB_SENSE_BYTES];
  logic [PFCB_NEV-1:0] ev;
  logic [PFCB_NEV-1:0] mask_q;
  logic [PFCB_NEV-1:0] stat;
  logic plb_wide_q;
  logic par_s1_q;
  logic par_q;
  logic step;
  logic wr;
  logic rd;
  logic cmd_wr;
  logic data_wr;
  logic [2:0] op;
  logic [3:0] arg;
  logic [PFCB_EW-1:0] cur;
  logic [PFCB_AW-1:0] line_next;
  logic at_end;
  logic ch_hit;
  logic passes_done;
  logic no_last;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign cmd_wr = wr && paddr == PFCB_A_CMD;
  assign data_wr = wr && paddr == PFCB_A_DATA;
  assign op = pwdata[PFCB_OP_MSB:0];
  assign arg = pwdata[PFCB_ARG_MSB:PFCB_ARG_LSB];
  assign cur = forms_control_buffer[line_q - PFCB_TOP];
  assign at_end = cur[PFCB_F_LAST] || line_q == PFCB_BOTTOM;
  assign line_next = at_end ? PFCB_TOP : line_q + PFCB_TOP;
  assign ch_hit = cur[PFCB_CH_MSB:0] == want_q && want_q != PFCB_CH_NONE;
  assign passes_done = line_q == PFCB_TOP && top_seen_q == PFCB_PASSES;
  assign no_last = !seen_last_q && load_ptr_q <= PFCB_BOTTOM;

  // parity fault pin from the printer side
  always_ff @(posedge mclk) begin
    if (rst) begin
      par_s1_q <= 1'b0;
      par_q <= 1'b0;
    end else begin
      par_s1_q <= plb_parity_err;
      par_q <= par_s1_q;
    end
  end

  pfcb_step_div u_div (
    .mclk(mclk),
    .rst(rst),
    .run(state_q == PFCB_SPACING || state_q == PFCB_SKIPPING),
    .step(step)
  );

  // apb: zero wait states, addresses above 0x1C give slverr
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > PFCB_A_CFG;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          PFCB_A_LINE: prdata <= {24'h000000, line_q};
          // an event landing now reaches stat before the read clear
          PFCB_A_STAT: prdata <= {27'h0000000, stat | ev};
          PFCB_A_MASK: prdata <= {27'h0000000, mask_q};
          PFCB_A_CMD: prdata <= {29'h00000000,
                                state_q == PFCB_IDLE ? 3'h0 : 3'h1};
          PFCB_A_SENSE0: prdata <= {sense_q[3], sense_q[2],
                                    sense_q[1], sense_q[0]};
          PFCB_A_SENSE1: prdata <= {16'h0000, sense_q[5], sense_q[4]};
          PFCB_A_CFG: prdata <= {31'h00000000, plb_wide_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // zero-wait access: pready is high in the access cycle
  // configuration registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_q <= {PFCB_NEV{1'b0}};
      plb_wide_q <= 1'b0;
    end else begin
      if (wr && paddr == PFCB_A_MASK) begin
        mask_q <= pwdata[PFCB_NEV-1:0];
      end
      if (wr && paddr == PFCB_A_CFG) begin
        plb_wide_q <= pwdata[0];
      end
    end
  end

  // buffer store during a load
  always_ff @(posedge mclk) begin
    if (state_q == PFCB_LOADING && data_wr &&
        load_ptr_q <= PFCB_BOTTOM) begin
      forms_control_buffer[load_ptr_q - PFCB_TOP] <=
        pwdata[PFCB_EW-1:0];
    end
  end

  // command sequencer
  always_ff @(posedge mclk) begin
    ev <= {PFCB_NEV{1'b0}};
    if (rst) begin
      state_q <= PFCB_IDLE;
      line_q <= PFCB_TOP;
      load_ptr_q <= PFCB_TOP;
      want_q <= PFCB_CH_NONE;
      count_q <= 4'h0;
      top_seen_q <= 2'h0;
      seen_last_q <= 1'b0;
      bad_code_q <= 1'b0;
      carriage_step <= 1'b0;
      lpi8 <= 1'b0;
      ev <= {PFCB_NEV{1'b0}};
      for (int k = 0; k < PFCB_SENSE_BYTES; k++) begin
        sense_q[k] <= 8'h00;
      end
    end else begin
      carriage_step <= 1'b0;
      // sense bytes 4 and 5 mirror the print width and the line spacing
      sense_q[4] <= plb_wide_q ? 8'(PFCB_PLB_MAX) : 8'(PFCB_PLB_STD);
      sense_q[5] <= lpi8 ? PFCB_LPI_EIGHT : PFCB_LPI_SIX;
      if (par_q) begin
        sense_q[0][PFCB_SN_PARITY] <= 1'b1;
        sense_q[1] <= line_q;
      end
      case (state_q)
        PFCB_IDLE: begin
          if (cmd_wr) begin
            sense_q[0] <= {7'h00, par_q};
            case (op)
              PFCB_OP_LOAD: begin
                load_ptr_q <= PFCB_TOP;
                seen_last_q <= 1'b0;
                bad_code_q <= 1'b0;
                state_q <= PFCB_LOADING;
              end
              PFCB_OP_SPACE: begin
                if (par_q) begin
                  ev[PFCB_S_PARITY] <= 1'b1;
                  ev[PFCB_S_DONE] <= 1'b1;
                end else begin
                  count_q <= arg;
                  state_q <= PFCB_SPACING;
                end
              end
              PFCB_OP_SKIP: begin
                if (par_q) begin
                  ev[PFCB_S_PARITY] <= 1'b1;
                  ev[PFCB_S_DONE] <= 1'b1;
                end else begin
                  want_q <= arg;
                  sense_q[2] <= {4'h0, arg};
                  top_seen_q <= 2'h0;
                  state_q <= PFCB_SKIPPING;
                end
              end
              PFCB_OP_PRINT: begin
                ev[PFCB_S_DONE] <= 1'b1;
                if (par_q) begin
                  ev[PFCB_S_PARITY] <= 1'b1;
                end
              end
              default: begin
                ev[PFCB_S_DONE] <= 1'b1;
              end
            endcase
          end
        end
        PFCB_LOADING: begin
          if (data_wr) begin
            if (load_ptr_q > PFCB_BOTTOM) begin
              sense_q[0][PFCB_SN_OVFL] <= 1'b1;
            end else begin
              if (pwdata[PFCB_F_LAST]) begin
                seen_last_q <= 1'b1;
              end
              if (pwdata[PFCB_CH_MSB:0] > PFCB_CH_MAX) begin
                bad_code_q <= 1'b1;
              end
              if (load_ptr_q == PFCB_TOP) begin
                lpi8 <= pwdata[PFCB_F_LPI8];
              end
              load_ptr_q <= load_ptr_q + PFCB_TOP;
            end
          end
          if (cmd_wr && op == PFCB_OP_END) begin
            state_q <= PFCB_IDLE;
            ev[PFCB_S_DONE] <= 1'b1;
            // a full 180-line image needs no flag
            sense_q[3] <= load_ptr_q - PFCB_TOP;
            if (no_last || bad_code_q) begin
              ev[PFCB_S_LDERR] <= 1'b1;
              sense_q[0][PFCB_SN_NOLAST] <= no_last;
              sense_q[0][PFCB_SN_BADCH] <= bad_code_q;
            end else begin
              ev[PFCB_S_LDOK] <= 1'b1;
              line_q <= PFCB_TOP;
            end
          end
        end
        PFCB_SPACING: begin
          if (count_q == 4'h0 || par_q) begin
            ev[PFCB_S_PARITY] <= par_q;
            ev[PFCB_S_DONE] <= 1'b1;
            state_q <= PFCB_IDLE;
          end else if (step) begin
            carriage_step <= 1'b1;
            line_q <= line_next;
            count_q <= count_q - 4'h1;
          end
        end
        PFCB_SKIPPING: begin
          if (par_q) begin
            ev[PFCB_S_PARITY] <= 1'b1;
            ev[PFCB_S_DONE] <= 1'b1;
            state_q <= PFCB_IDLE;
          end else if (step) begin
            carriage_step <= 1'b1;
            line_q <= line_next;
            if (line_next == PFCB_TOP) begin
              top_seen_q <= top_seen_q + 2'h1;
            end
            state_q <= PFCB_LOOK;
          end
        end
        PFCB_LOOK: begin
          if (ch_hit) begin
            ev[PFCB_S_DONE] <= 1'b1;
            state_q <= PFCB_IDLE;
          end else if (passes_done) begin
            ev[PFCB_S_RUNAWAY] <= 1'b1;
            ev[PFCB_S_DONE] <= 1'b1;
            sense_q[0][PFCB_SN_RUNAWAY] <= 1'b1;
            sense_q[1] <= line_q;
            state_q <= PFCB_IDLE;
          end else begin
            state_q <= PFCB_SKIPPING;
          end
        end
        default: state_q <= PFCB_IDLE;
      endcase
    end
  end

  pfcb_irq u_irq (
    .mclk(mclk),
    .rst(rst),
    .ev(ev),
    .rd_clr(pready && rd && paddr == PFCB_A_STAT),
    .mask(mask_q),
    .stat(stat),
    .irq(irq)
  );
endmodule
`default_nettype wire

// >>> pfcb_pkg.sv
// package of constants for the forms control buffer block
// assumes a 32-bit apb register bus and a single 10 MHz clock
package pfcb_pkg;
  localparam int unsigned PFCB_LINES = 180;
  localparam int unsigned PFCB_AW = 8;
  localparam int unsigned PFCB_PLB_STD = 132;
  localparam int unsigned PFCB_PLB_MAX = 150;
  localparam int unsigned PFCB_SENSE_BYTES = 6;
  // entry layout: [3:0] channel code, [4] last line, [5] eight lpi
  localparam int unsigned PFCB_EW = 6;
  localparam int unsigned PFCB_F_LAST = 4;
  localparam int unsigned PFCB_F_LPI8 = 5;
  localparam int unsigned PFCB_CH_MSB = 3;
  localparam logic [3:0] PFCB_CH_NONE = 4'h0;
  localparam logic [3:0] PFCB_CH_MAX = 4'hC;
  localparam logic [PFCB_AW-1:0] PFCB_TOP = 8'h01;
  localparam logic [PFCB_AW-1:0] PFCB_BOTTOM = 8'hB4;
  // register byte addresses
  localparam logic [7:0] PFCB_A_CMD = 8'h00;
  localparam logic [7:0] PFCB_A_DATA = 8'h04;
  localparam logic [7:0] PFCB_A_LINE = 8'h08;
  localparam logic [7:0] PFCB_A_STAT = 8'h0C;
  localparam logic [7:0] PFCB_A_MASK = 8'h10;
  localparam logic [7:0] PFCB_A_SENSE0 = 8'h14;
  localparam logic [7:0] PFCB_A_SENSE1 = 8'h18;
  localparam logic [7:0] PFCB_A_CFG = 8'h1C;
  // command register: [2:0] opcode, [7:4] channel or space count
  localparam int unsigned PFCB_OP_MSB = 2;
  localparam int unsigned PFCB_ARG_LSB = 4;
  localparam int unsigned PFCB_ARG_MSB = 7;
  // runaway stop after line 1 is met this many times
  localparam logic [1:0] PFCB_PASSES = 2'h2;
  // line spacing as reported in sense byte 5
  localparam logic [7:0] PFCB_LPI_SIX = 8'h06;
  localparam logic [7:0] PFCB_LPI_EIGHT = 8'h08;
  localparam logic [2:0] PFCB_OP_SPACE = 3'h1;
  localparam logic [2:0] PFCB_OP_SKIP = 3'h2;
  localparam logic [2:0] PFCB_OP_LOAD = 3'h3;
  localparam logic [2:0] PFCB_OP_END = 3'h4;
  localparam logic [2:0] PFCB_OP_PRINT = 3'h5;
  // status bits
  localparam int unsigned PFCB_NEV = 5;
  localparam int unsigned PFCB_S_DONE = 0;
  localparam int unsigned PFCB_S_LDERR = 1;
  localparam int unsigned PFCB_S_RUNAWAY = 2;
  localparam int unsigned PFCB_S_PARITY = 3;
  localparam int unsigned PFCB_S_LDOK = 4;
  // sense byte 0 bits
  localparam int unsigned PFCB_SN_PARITY = 0;
  localparam int unsigned PFCB_SN_NOLAST = 1;
  localparam int unsigned PFCB_SN_BADCH = 2;
  localparam int unsigned PFCB_SN_RUNAWAY = 3;
  localparam int unsigned PFCB_SN_OVFL = 4;
  // carriage step pacing, one line per step time
  localparam int unsigned PFCB_STEP_NS = 1000;
  localparam int unsigned PFCB_CLK_NS = 100;
  localparam int unsigned PFCB_STEP_CYC = PFCB_STEP_NS / PFCB_CLK_NS;
  typedef enum logic [2:0] {
    PFCB_IDLE, PFCB_LOADING, PFCB_SPACING, PFCB_SKIPPING, PFCB_LOOK
  } pfcb_state_t;
endpackage

// >>> pfcb_step_div.sv
// step divider: one-cycle enable pulse per carriage line time
// assumes mclk at the rate given in the package
`timescale 1ns/10ps
`default_nettype none
module pfcb_step_div (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  output logic step
);
  import pfcb_pkg::*;
  logic [7:0] cnt_q;
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      cnt_q <= 8'h00;
      step <= 1'b0;
    end else if (cnt_q == 8'(PFCB_STEP_CYC - 1)) begin
      cnt_q <= 8'h00;
      step <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      step <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> pfcb_irq.sv
// sticky event status, mask and level interrupt
// events come from logic on mclk; a status read clears all bits except those with a new event in the same cycle
`timescale 1ns/10ps
`default_nettype none
module pfcb_irq (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [pfcb_pkg::PFCB_NEV-1:0] ev,
  input wire logic rd_clr,
  input wire logic [pfcb_pkg::PFCB_NEV-1:0] mask,
  output logic [pfcb_pkg::PFCB_NEV-1:0] stat,
  output logic irq
);
  import pfcb_pkg::*;
  genvar i;
  generate
    for (i = 0; i < PFCB_NEV; i++) begin : g_bit
      // a new event wins over the read clear
      always_ff @(posedge mclk) begin
        if (rst) begin
          stat[i] <= 1'b0;
        end else if (ev[i]) begin
          stat[i] <= 1'b1;
        end else if (rd_clr) begin
          stat[i] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((stat | ev) & ~(rd_clr ? ~ev : {PFCB_NEV{1'b0}}) & mask);
    end
  end
endmodule
`default_nettype wire

// >>> pfcb_checker.sv
// port-level checker for pfcb_top
// sees only the top ports; bound in at the foot
`timescale 1ns/10ps
`default_nettype none
module pfcb_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic plb_parity_err,
  input wire logic carriage_step,
  input wire logic lpi8,
  input wire logic irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_quiet;
    !carriage_step [*4];
  endsequence
  property p_ready_acc;
    s_setup |=> pready;
  endproperty
  a_ready_acc: assert property (p_ready_acc) else $error("ready late");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready long");
  property p_ready_qual;
    pready |-> psel && penable;
  endproperty
  a_ready_qual: assert property (p_ready_qual) else $error("stray ready");
  property p_slv_hi;
    s_setup ##0 (paddr > 8'h1C) |=> pslverr;
  endproperty
  a_slv_hi: assert property (p_slv_hi) else $error("no slverr");
  property p_slv_lo;
    s_setup ##0 (paddr <= 8'h1C) |=> !pslverr;
  endproperty
  a_slv_lo: assert property (p_slv_lo) else $error("bad slverr");
  property p_slv_rdy;
    pslverr |-> pready;
  endproperty
  a_slv_rdy: assert property (p_slv_rdy) else $error("slverr alone");
  property p_step_gap;
    carriage_step |=> s_quiet;
  endproperty
  a_step_gap: assert property (p_step_gap) else $error("steps close");
  property p_lpi_still;
    carriage_step |-> $stable(lpi8);
  endproperty
  a_lpi_still: assert property (p_lpi_still) else $error("lpi moved");
  property p_rst_quiet;
    disable iff (1'b0) rst |=> !carriage_step && !irq && !pready && !lpi8;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset out");
endmodule
bind pfcb_top pfcb_checker i_chk (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .plb_parity_err(plb_parity_err), .carriage_step(carriage_step),
  .lpi8(lpi8), .irq(irq));
`default_nettype wire

// >>> pfcb_host_model.sv
// host channel model: issues apb transfers to the printer block
// assumes the apb slave timing of pfcb_top on mclk
`timescale 1ns/10ps
`default_nettype none
module pfcb_host_model (
  input wire logic mclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic hung
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // request held until pready is sampled; bus garbled once released
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) hung <= 1'b1;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// >>> pfcb_bench.sv
// self-checking bench for pfcb_top driven through the host model
// assumes 10 MHz mclk and sync active-high reset
`timescale 1ns/10ps
`default_nettype none
module pfcb_bench;
  import pfcb_pkg::*;
  logic mclk, rst, plb_parity_err, psel, penable, pwrite, hung, e;
  logic pready, pslverr, carriage_step, lpi8, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [5:0] ent [1:180];
  int err_count, n_tests, n_steps;
  pfcb_top i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .plb_parity_err(plb_parity_err),
    .carriage_step(carriage_step), .lpi8(lpi8), .irq(irq));
  pfcb_host_model i_host (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hung(hung));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) if (carriage_step === 1'b1) n_steps++;
  always @(posedge mclk) if (hung === 1'b1) begin
    err_count++;
    stop_test();
  end
  task automatic stop_test();
    $display("mismatches %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x,
    input string m);
    n_tests++;
    if (s !== x) begin
      err_count++;
      $display("MISMATCH t=%0t %s seen %0h exp %0h", $time, m, s, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic x;
    i_host.xfer(1'b1, a, d, r, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic x;
    i_host.xfer(1'b0, a, 32'h0, r, x);
  endtask
  task automatic wait_idle();
    logic [31:0] r;
    int n;
    n = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && n < 3000) begin
      rd(PFCB_A_CMD, r);
      n++;
    end
    if (n >= 3000) begin
      err_count++;
      stop_test();
    end
    repeat (2) @(posedge mclk);
  endtask
  task automatic go(input logic [2:0] op, input logic [3:0] arg);
    n_steps = 0;
    wr(PFCB_A_CMD, {24'h0, arg, 1'b0, op});
    wait_idle();
  endtask
  task automatic load(input int n);
    wr(PFCB_A_CMD, {29'h0, PFCB_OP_LOAD});
    for (int i = 1; i <= n; i++) wr(PFCB_A_DATA, {26'h0, ent[i]});
    wr(PFCB_A_CMD, {29'h0, PFCB_OP_END});
    wait_idle();
  endtask
  task automatic line_is(input int l, input int s);
    logic [31:0] r;
    rd(PFCB_A_LINE, r);
    chk(r, 32'(l), "line");
    chk(32'(n_steps), 32'(s), "steps");
  endtask
  task automatic flag(input logic [7:0] a, input int b, input string m);
    logic [31:0] r;
    rd(a, r);
    chk(32'(r[b]), 32'h1, m);
  endtask
  initial begin
    rst = 1'b1;
    plb_parity_err = 1'b0;
    err_count = 0;
    n_tests = 0;
    n_steps = 0;
    for (int i = 1; i <= 180; i++) ent[i] = 6'h00;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    line_is(1, 0);
    wr(PFCB_A_MASK, 32'h10);
    rd(PFCB_A_MASK, q);
    chk(q, 32'h10, "mask");
    wr(PFCB_A_CFG, 32'h1);
    rd(PFCB_A_CFG, q);
    chk(q, 32'h1, "wide option");
    i_host.xfer(1'b0, 8'h20, 32'h0, q, e);
    chk(32'(e), 32'h1, "unmapped");
    $display("test registers done");
    ent[1] = 6'h20;
    ent[4] = 6'h05;
    ent[6] = 6'h10;
    load(6);
    chk(32'(irq), 32'h1, "irq up");
    rd(PFCB_A_STAT, q);
    chk(32'(q[PFCB_S_LDOK]), 32'h1, "load ok");
    chk(32'(q[PFCB_S_LDERR]), 32'h0, "load err");
    line_is(1, 0);
    chk(32'(irq), 32'h0, "irq clear");
    chk(32'(lpi8), 32'h1, "eight lpi");
    rd(PFCB_A_SENSE1, q);
    chk(q, 32'h00000896, "width and lpi sense");
    go(PFCB_OP_SPACE, 4'h2);
    line_is(3, 2);
    go(PFCB_OP_SKIP, 4'h5);
    line_is(4, 1);
    go(PFCB_OP_SKIP, 4'h5);
    line_is(4, 6);
    go(PFCB_OP_SKIP, 4'h9);
    line_is(1, 9);
    flag(PFCB_A_STAT, PFCB_S_RUNAWAY, "runaway");
    flag(PFCB_A_SENSE0, PFCB_SN_RUNAWAY, "runaway sense");
    rd(PFCB_A_SENSE0, q);
    chk(q, 32'h06090108, "sense detail");
    $display("test short form done");
    plb_parity_err <= 1'b1;
    repeat (4) @(posedge mclk);
    go(PFCB_OP_SPACE, 4'h1);
    line_is(1, 0);
    flag(PFCB_A_SENSE0, PFCB_SN_PARITY, "parity sense");
    flag(PFCB_A_STAT, PFCB_S_PARITY, "parity event");
    go(PFCB_OP_PRINT, 4'h0);
    line_is(1, 0);
    flag(PFCB_A_STAT, PFCB_S_PARITY, "print parity");
    plb_parity_err <= 1'b0;
    repeat (4) @(posedge mclk);
    $display("test parity done");
    for (int k = 0; k < 2; k++) begin
      ent[1] = 6'h00;
      ent[2] = (k == 1) ? 6'h0D : 6'h00;
      ent[3] = (k == 1) ? 6'h10 : 6'h00;
      load(3);
      flag(PFCB_A_STAT, PFCB_S_LDERR, "load err");
      flag(PFCB_A_SENSE0, k ? PFCB_SN_BADCH : PFCB_SN_NOLAST, "cause");
    end
    $display("test load errors done");
    for (int i = 1; i <= 180; i++) begin
      ent[i] = (i >= 10 && i <= 21) ? 6'(i - 9) : 6'h00;
    end
    load(180);
    flag(PFCB_A_STAT, PFCB_S_LDOK, "full load");
    chk(32'(lpi8), 32'h0, "six lpi");
    rd(PFCB_A_SENSE1, q);
    chk(q, 32'h00000696, "six lpi sense");
    rd(PFCB_A_SENSE0, q);
    chk(32'(q[31:24]), 32'h000000B4, "entries");
    for (int c = 1; c <= 12; c++) begin
      go(PFCB_OP_SKIP, 4'(c));
      line_is(9 + c, (c == 1) ? 9 : 1);
    end
    go(PFCB_OP_SKIP, 4'h1);
    line_is(10, 169);
    go(PFCB_OP_SPACE, 4'hF);
    line_is(25, 15);
    $display("test full form done");
    stop_test();
  end
endmodule
`default_nettype wire
